/* hw/dcrb_dev.sv */
// Device end: receives serial words, holds setup registers, answers
// readback. Assumes the host keeps sclk, sdata and latch synchronous
// to clk_i; data sampled on the sclk rising edge, rdata changes on fall.
`timescale 1ns/100ps
// How it works
// - Q mixer load side A, bits 17-22
// - Q mixer load side B, bits 23-28
// - Host keeps mixer load fields zero; dcrb_host sends the word as written
// - Bypass bit 29, peaking 30-31 resets 01
// - Register four needs no programming
// - Bits 0-2 register, 3-4 bank address
// - Six two-bit trims bits 5-16, reset 01
// - Host leaves trims at one; dcrb_host sends the word as written
// - Optional trim set 2,3,0,1,2,1
// - Readback request 0,0,0,1,0 plus address
// - Readback address, version, Q and I DAC
// - Readback register select reads zero default
// - Readback bank reads 1,0 default
// - DC offset registers start at 128
module dcrb_dev #(
   parameter logic [1:0] VERSION = 2'h2 // Arbitrary version code value
) (
   input wire logic clk_i,
   input wire logic rst_i,
   dcrb_if.dev link,
   input wire logic dac_load_i,          // Calibration result strobe
   input wire logic [7:0] dac_q_i,       // New Q offset DAC value
   input wire logic [7:0] dac_i_i,       // New I offset DAC value
   output logic [5:0] q_mixer_load_side_a_o,
   output logic [5:0] q_mixer_load_side_b_o,
   output logic filter_bypass_o,
   output logic [1:0] peaking_ctrl_o,
   output logic [11:0] bias_trims_o,     // Six trims, first at bit 0
   output logic [7:0] dac_q_o,
   output logic [7:0] dac_i_o
);
   logic [31:0] mix_q, mix_d;     // Mixer and filter setup word
   logic [31:0] bias_q, bias_d;   // Bias trim setup word
   logic [7:0] dq_q, dq_d;        // Q offset DAC register
   logic [7:0] di_q, di_d;        // I offset DAC register
   logic [4:0] rba_q, rba_d;      // Address echoed in readback
   logic sclk_q;                  // Last sclk for edge detect
   logic rise, fall;              // One-cycle sclk edge pulses
   logic [31:0] rx_word;          // Receive shifter contents
   logic [31:0] tx_word;          // Readback word to load
   logic tx_load;                 // Load the readback word
   logic [2:0] w_reg;             // Register field of received word
   logic [1:0] w_bank;            // Bank field of received word
   logic cmd_mix, cmd_bias;       // Word addresses a setup register
   logic cmd_rdbk;                // Word is a readback request

   // Match a received address pair against one command. Every command
   // test goes through here, so no two of them can ever disagree on
   // how the address and bank fields are read
   function automatic logic addr_is(input logic [2:0] reg_w,
                                    input logic [1:0] bank_w,
                                    input logic [2:0] reg_f,
                                    input logic [1:0] bank_f);
      addr_is = (reg_w == reg_f) && (bank_w == bank_f);
   endfunction

   // The field slices below assume the documented 32-bit word
   if (dcrb_pkg::WORD_W != 32) begin : g_word_chk
      $error("dcrb_dev serves 32-bit words only");
   end

   // One host bit takes four clk_i cycles: sclk low for two, high for
   // two. The host moves sdata only while sclk is low, so the rise
   // always sees a settled bit. The fall steps the transmit shifter,
   // which gives rdata a cycle to settle before the host samples it at
   // the end of that same low phase. latch rises with the last fall, sclk low again.
   // A frame cut short before latch changes no setup register; the
   // next full frame shifts the stale bits out of the way. The edge
   // detector resets low, matching the idle level of sclk, so no
   // false rise follows reset.

   // Sclk edges; host drives sclk as a clk_i-synchronous level
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sclk_q <= 1'b0;
      end else begin
         sclk_q <= link.sclk;
      end
   end
   assign rise = link.sclk & ~sclk_q;
   assign fall = ~link.sclk & sclk_q;

   // Receive shifter; bit 0 enters first and ends at the bottom once
   // all 32 rises have passed
   dcrb_shift u_rx (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .load_i(1'b0),
      .load_val_i('0),
      .shift_i(rise),
      .in_bit_i(link.sdata),
      .out_bit_o(),
      .word_o(rx_word)
   );

   // Address fields of the received word; they only mean something
   // at latch, once all 32 bits have arrived
   assign w_reg = rx_word[dcrb_pkg::ADDR_LSB +: dcrb_pkg::ADDR_W];
   assign w_bank = rx_word[dcrb_pkg::BANK_LSB +: dcrb_pkg::BANK_W];

   // Command decode: setup writes live in bank one at registers three
   // and five; the readback request is register zero of bank one
   assign cmd_mix = addr_is(w_reg, w_bank, dcrb_pkg::REG_MIX,
                            dcrb_pkg::BANK_SETUP);
   assign cmd_bias = addr_is(w_reg, w_bank, dcrb_pkg::REG_BIAS,
                             dcrb_pkg::BANK_SETUP);
   assign cmd_rdbk = addr_is(w_reg, w_bank, dcrb_pkg::REG_RDBK,
                             dcrb_pkg::BANK_RDBK);

   // Readback word built from the next echo address, not the stored
   // one: the shifter loads at the same edge that updates the echo,
   // and the stored value would still name the previous request
   assign tx_word = {di_q, dq_q, 9'h0, VERSION, rba_d};

   // Readback loads on the latch of a readback request
   assign tx_load = link.latch && cmd_rdbk;

   // Transmit shifter, shifts out on sclk falling edge; zeros fill in
   // behind, so a second frame without a new request reads as zero
   dcrb_shift u_tx (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .load_i(tx_load),
      .load_val_i(tx_word),
      .shift_i(fall),
      .in_bit_i(1'b0),
      .out_bit_o(link.rdata),
      .word_o()
   );

   // Setup and echo registers. The whole word commits only on latch,
   // so a half-shifted word never reaches the analog controls
   always_comb begin
      mix_d = mix_q;
      bias_d = bias_q;
      rba_d = rba_q;
      if (link.latch) begin
         if (cmd_mix) begin // Mixer and filter setup
            mix_d = rx_word;
         end else if (cmd_bias) begin // Bias trim setup
            bias_d = rx_word;
         end
         // Other addresses, register four included, are ignored; spare
         // bits are kept as sent and drive nothing
      end
      // Echo bank one and the register that the request names
      if (tx_load) begin
         rba_d = {dcrb_pkg::BANK_SETUP,
                  rx_word[dcrb_pkg::RQ_ADDR_LSB +: dcrb_pkg::ADDR_W]};
      end
   end

   // Register only; setup words start at their documented defaults
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         mix_q <= dcrb_pkg::MIX_RST;
         bias_q <= dcrb_pkg::BIAS_RST;
         rba_q <= {dcrb_pkg::RB_BANK_RST, dcrb_pkg::RB_ADDR_RST};
      end else begin
         mix_q <= mix_d;
         bias_q <= bias_d;
         rba_q <= rba_d;
      end
   end

   // Offset DAC registers: only the calibration engine writes them,
   // so a host frame can never disturb a finished calibration
   always_comb begin
      dq_d = dq_q;
      di_d = di_q;
      if (dac_load_i) begin // New calibration result
         dq_d = dac_q_i;
         di_d = dac_i_i;
      end
   end

   // Register only; half scale after reset, so the correction starts
   // from the middle of its range
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         dq_q <= dcrb_pkg::DAC_RST;
         di_q <= dcrb_pkg::DAC_RST;
      end else begin
         dq_q <= dq_d;
         di_q <= di_d;
      end
   end

   // Field views straight from the registers, so every control output
   // is a flop output and never glitches while a frame shifts in.
   // Peaking is passed on as written: picking 0 in bypass and 1
   // otherwise is left to the host
   assign q_mixer_load_side_a_o =
      mix_q[dcrb_pkg::QLA_LSB +: dcrb_pkg::LOAD_W];
   assign q_mixer_load_side_b_o =
      mix_q[dcrb_pkg::QLB_LSB +: dcrb_pkg::LOAD_W];
   assign filter_bypass_o = mix_q[dcrb_pkg::BYP_BIT];
   assign peaking_ctrl_o = mix_q[dcrb_pkg::PEAK_LSB +: 2];
   assign bias_trims_o =
      bias_q[dcrb_pkg::TRIM_LSB +: 2 * dcrb_pkg::TRIM_N];
   assign dac_q_o = dq_q;
   assign dac_i_o = di_q;
endmodule

/* hw/dcrb_pkg.sv */
// Shared constants for the demodulator configuration register bank.
// Assumes both ends and the bench compile this package first.
package dcrb_pkg;
   localparam int WORD_W = 32;                 // Serial word length
   localparam int CNT_W = 5;                   // Bit counter width
   localparam int ADDR_LSB = 0;                // Register address field
   localparam int ADDR_W = 3;
   localparam int BANK_LSB = 3;                // Bank address field
   localparam int BANK_W = 2;
   localparam logic [2:0] REG_MIX = 3'h3;      // Mixer and filter setup
   localparam logic [2:0] REG_BIAS = 3'h5;     // Bias trim setup
   localparam logic [2:0] REG_RDBK = 3'h0;     // Readback request / word
   localparam logic [1:0] BANK_SETUP = 2'h1;   // Bank of setup words
   // A readback request is register zero of the setup bank: its low
   // five bits are 0,0,0,1,0, so bit 3 is set just as in a setup word
   localparam logic [1:0] BANK_RDBK = 2'h1;    // Bank of readback request
   // Mixer setup fields
   localparam int QLA_LSB = 17;
   localparam int QLB_LSB = 23;
   localparam int LOAD_W = 6;
   localparam int BYP_BIT = 29;
   localparam int PEAK_LSB = 30;
   localparam logic [1:0] PEAK_RST = 2'h1;
   // Bias trim fields: six two-bit fields from bit 5
   localparam int TRIM_LSB = 5;
   localparam int TRIM_N = 6;
   localparam logic [1:0] TRIM_RST = 2'h1;
   // Readback request carries the wanted register in bits 21..23
   localparam int RQ_ADDR_LSB = 21;
   // Readback word fields
   localparam int VER_LSB = 5;
   localparam int DACQ_LSB = 16;
   localparam int DACI_LSB = 24;
   localparam logic [7:0] DAC_RST = 8'h80;     // Half scale
   localparam logic [2:0] RB_ADDR_RST = 3'h0;
   localparam logic [1:0] RB_BANK_RST = 2'h1;  // Bit 3 set, bit 4 clear
   localparam logic [31:0] MIX_RST = {PEAK_RST, 30'h0};
   localparam logic [31:0] BIAS_RST = {15'h0, {TRIM_N{TRIM_RST}}, 5'h0};
   localparam int CLK_DIV = 4;                 // Serial clock divider
endpackage

/* hw/dcrb_if.sv */
// Four-wire serial link between host and register bank.
// Assumes a shared clk_i; serial clock is an enable-qualified level.
`timescale 1ns/100ps
interface dcrb_if;
   logic sclk;   // Serial clock, driven by host
   logic sdata;  // Data host to device, bit 0 first
   logic latch;  // Strobe after 32 bits: commit word
   logic rdata;  // Readback data device to host
   modport host (output sclk, output sdata, output latch, input rdata);
   modport dev (input sclk, input sdata, input latch, output rdata);
endinterface

/* hw/dcrb_shift.sv */
// Generic 32-bit shift register stepped by a one-cycle enable.
// Assumes the caller supplies load and shift enables, bit 0 first.
`timescale 1ns/100ps
module dcrb_shift #(
   parameter int W = dcrb_pkg::WORD_W
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic load_i,
   input wire logic [W-1:0] load_val_i,
   input wire logic shift_i,
   input wire logic in_bit_i,
   output logic out_bit_o,
   output logic [W-1:0] word_o
);
   logic [W-1:0] sr_q, sr_d; // Shift contents

   // A one-bit shifter has no slice to move; refuse it at elaboration
   if (W < 2) begin : g_width_chk
      $error("dcrb_shift needs at least two bits");
   end

   // Load wins over shift; bits enter at the top, leave at bit 0
   always_comb begin
      sr_d = sr_q;
      if (load_i) begin
         sr_d = load_val_i;
      end else if (shift_i) begin
         sr_d = {in_bit_i, sr_q[W-1:1]};
      end
   end

   // Register only
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sr_q <= '0;
      end else begin
         sr_q <= sr_d;
      end
   end

   assign out_bit_o = sr_q[0];
   assign word_o = sr_q;
endmodule

/* hw/dcrb_host.sv */
// Host end: takes words from software registers, shifts them out
// and collects the readback. Assumes one clock; sclk from a divider.
`timescale 1ns/100ps
module dcrb_host (
   input wire logic clk_i,
   input wire logic rst_i,
   dcrb_if.host link,
   input wire logic [1:0] addr_i,      // 0 data, 1 go, 2 status, 3 rdbk
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o
);
   typedef enum logic [1:0] {DCRB_IDLE, DCRB_SHIFT, DCRB_LATCH} dcrb_st_t;
   dcrb_st_t st_q, st_d;
   logic [31:0] data_q, data_d;      // Word to send
   logic [31:0] rx_q, rx_d;          // Readback collected
   logic [4:0] bit_q, bit_d;         // Bits sent
   logic [1:0] div_q, div_d;         // Sclk phase divider
   logic [31:0] rd_q, rd_d;          // Read data register

   // Sequence: low phase, high phase per bit; bit 0 first
   always_comb begin
      st_d = st_q;
      data_d = data_q;
      rx_d = rx_q;
      bit_d = bit_q;
      div_d = div_q;
      rd_d = '0;
      if (wr_i && addr_i == 2'h0 && st_q == DCRB_IDLE) begin
         data_d = wdata_i; // Host owns content choice
      end
      case (st_q)
         DCRB_IDLE: begin
            if (wr_i && addr_i == 2'h1) begin
               st_d = DCRB_SHIFT;
               bit_d = '0;
               div_d = '0;
            end
         end
         DCRB_SHIFT: begin
            div_d = div_q + 2'h1;
            if (div_q == 2'h1) begin // Sclk rise: sample rdata
               rx_d = {link.rdata, rx_q[31:1]};
            end
            if (div_q == 2'h3) begin
               data_d = {1'b0, data_q[31:1]};
               bit_d = bit_q + 5'h1;
               if (bit_q == 5'h1f) begin
                  st_d = DCRB_LATCH;
               end
            end
         end
         DCRB_LATCH: begin
            st_d = DCRB_IDLE;
         end
         default: begin
            st_d = DCRB_IDLE;
         end
      endcase
      if (rd_i) begin
         case (addr_i)
            2'h0: rd_d = data_q;
            2'h2: rd_d = {31'h0, st_q != DCRB_IDLE};
            2'h3: rd_d = rx_q;
            default: rd_d = '0;
         endcase
      end
   end

   // Register only
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_q <= DCRB_IDLE;
         data_q <= '0;
         rx_q <= '0;
         bit_q <= '0;
         div_q <= '0;
         rd_q <= '0;
      end else begin
         st_q <= st_d;
         data_q <= data_d;
         rx_q <= rx_d;
         bit_q <= bit_d;
         div_q <= div_d;
         rd_q <= rd_d;
      end
   end

   assign link.sclk = (st_q == DCRB_SHIFT) && div_q[1];
   assign link.sdata = data_q[0];
   assign link.latch = (st_q == DCRB_LATCH);
   assign rdata_o = rd_q;
endmodule

/* tb/dcrb_monitor.sv */
// Checker for the serial link that joins the host and device ends.
// Assumes it sits beside the interface and shares the system clock.
`timescale 1ns/100ps
module dcrb_monitor (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic sclk,
   input wire logic sdata,
   input wire logic latch,
   input wire logic rdata
);
   logic [5:0] cnt_q; // Serial clock rises since the last commit
   logic [5:0] cnt_d;
   logic sclk_q; // Serial clock one cycle back, for edge finding
   logic sclk_d;
   // Next count: a commit restarts the word, a rise adds one bit
   always_comb begin
      sclk_d = sclk;
      cnt_d = cnt_q;
      if (latch) begin
         cnt_d = 6'h0;
      end else if (sclk && !sclk_q) begin
         cnt_d = cnt_q + 6'h1;
      end
   end
   // Register the count
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_q <= 6'h0;
         sclk_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         sclk_q <= sclk_d;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // High for two cycles, then low
   sequence hi_two_s;
      sclk ##1 !sclk;
   endsequence
   latch_pulse_a: assert property (latch |=> !latch)
      else $error("commit strobe longer than one cycle");
   latch_low_a: assert property (latch |-> !sclk)
      else $error("commit while serial clock high");
   sclk_shape_a: assert property ($rose(sclk) |=> hi_two_s)
      else $error("serial clock high time wrong");
   word_count_a: assert property (latch |-> cnt_q == 6'd32)
      else $error("commit without exactly 32 bits");
   commit_soon_a: assert property (
      $rose(sclk) && cnt_q == 6'd31 |-> ##[1:8] latch)
      else $error("no commit after the last bit");
   count_cap_a: assert property (cnt_q <= 6'd32)
      else $error("more than 32 bits in one word");
   sdata_hold_a: assert property (
      sclk && $past(sclk) |-> $stable(sdata))
      else $error("host data moved while clock high");
   rdata_hold_a: assert property (
      sclk && $past(sclk) |-> $stable(rdata))
      else $error("readback moved while clock high");
endmodule

/* tb/dcrb_bench.sv */
// Bench: host and device ends joined over the link, against a model.
// Assumes the package and the interface are compiled before it.
`timescale 1ns/100ps
module dcrb_bench;
   localparam logic [1:0] VER = 2'h2; // Arbitrary version, as instanced
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [1:0] addr_i = 2'h0;
   logic [31:0] wdata_i = 32'h0, rdata_o;
   logic wr_i = 1'b0, rd_i = 1'b0, dac_load_i = 1'b0, byp;
   logic [7:0] dac_q_i = 8'h0, dac_i_i = 8'h0, dq, di, dq_m, di_m;
   logic [5:0] qa, qb;
   logic [1:0] pk;
   logic [11:0] tr;
   logic [31:0] mix_m, bias_m; // Model of the two setup words
   int err_total, n_checks;
   always #50 clk_i = ~clk_i;
   dcrb_if link ();
   dcrb_host u_dcrb_host (.clk_i(clk_i), .rst_i(rst_i), .link(link),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o));
   dcrb_dev #(.VERSION(VER)) u_dcrb_dev (.clk_i(clk_i), .rst_i(rst_i),
      .link(link), .dac_load_i(dac_load_i), .dac_q_i(dac_q_i),
      .dac_i_i(dac_i_i), .q_mixer_load_side_a_o(qa),
      .q_mixer_load_side_b_o(qb), .filter_bypass_o(byp),
      .peaking_ctrl_o(pk), .bias_trims_o(tr), .dac_q_o(dq), .dac_i_o(di));
   dcrb_monitor u_dcrb_monitor (.clk_i(clk_i), .rst_i(rst_i),
      .sclk(link.sclk), .sdata(link.sdata), .latch(link.latch),
      .rdata(link.rdata));
   // Compare one value; unknowns never match
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask
   // Verdict and end of run
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // One-cycle register write
   task automatic wr(logic [1:0] a, logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   // One-cycle read; data stand only in the next cycle
   task automatic rd(logic [1:0] a, output logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(negedge clk_i);
      d = rdata_o;
   endtask
   // Load a word, start it, poll busy under a bound
   task automatic send(logic [31:0] w);
      logic [31:0] s;
      wr(2'h0, w);
      wr(2'h1, 32'h1);
      s = 32'h1;
      for (int i = 0; i < 200 && s[0] !== 1'b0; i++) begin
         rd(2'h2, s);
      end
      if (s[0] !== 1'b0) begin
         err_total++;
         summarize();
      end
      repeat (2) @(posedge clk_i);
   endtask
   // All device outputs against the model
   task automatic chk_dev();
      chk("q_mixer_load_side_a", mix_m[22:17], qa);
      chk("q_mixer_load_side_b", mix_m[28:23], qb);
      chk("bypass", mix_m[29], byp);
      chk("peaking", mix_m[31:30], pk);
      chk("trims", bias_m[16:5], tr);
      chk("dac_q", dq_m, dq);
      chk("dac_i", di_m, di);
   endtask
   // Request a readback, clock it out with an ignored word, read it
   task automatic rb(logic [2:0] r);
      logic [31:0] d;
      send(32'h8 | (32'(r) << 21));
      send(32'h0);
      rd(2'h3, d);
      chk("readback", {di_m, dq_m, 9'h0, VER, 2'h1, r}, d);
   endtask
   initial begin
      logic [31:0] w;
      logic [4:0] bad [3];
      err_total = 0;
      n_checks = 0;
      w = $urandom(14);
      bad = '{5'h0c, 5'h03, 5'h1b}; // Register four, wrong banks
      mix_m = 32'h40000000;
      bias_m = 32'h0000aaa0;
      dq_m = 8'h80;
      di_m = 8'h80;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk_dev();
      rb(3'h0);
      $display("test reset done");
      // Random setup words back to back, mixer and trim in turn
      for (int k = 0; k < 6; k++) begin
         w = ($urandom() & 32'hffffffe0) | 32'h0b;
         if (k[0]) w[2:0] = 3'h5;
         send(w);
         if (k[0]) bias_m = w;
         else mix_m = w;
         chk_dev();
      end
      w = {15'h0, 2'h1, 2'h2, 2'h1, 2'h0, 2'h3, 2'h2, 5'h0d};
      send(w);
      bias_m = w;
      w = {2'h0, 1'b1, 24'h0, 5'h0b}; // Bypass with peaking zero
      send(w);
      mix_m = w;
      chk_dev();
      // Recommended settings: trims back at one, loads zero, peaking one
      w = 32'h0000aaad;
      send(w);
      bias_m = w;
      w = {2'h1, 1'b0, 24'h0, 5'h0b};
      send(w);
      mix_m = w;
      chk_dev();
      $display("test setup done");
      // Words to other places leave the setup untouched
      foreach (bad[j]) begin
         send(($urandom() & 32'hffffffe0) | 32'(bad[j]));
         chk_dev();
      end
      $display("test refused done");
      // New offset values, then read them back
      dq_m = 8'($urandom());
      di_m = 8'($urandom());
      @(posedge clk_i);
      dac_q_i <= dq_m;
      dac_i_i <= di_m;
      dac_load_i <= 1'b1;
      @(posedge clk_i);
      dac_load_i <= 1'b0;
      @(posedge clk_i);
      chk_dev();
      rb(3'h3);
      rb(3'h5);
      $display("test readback done");
      summarize();
   end
endmodule
